// >>> logic/wdf_tick_gen.sv
// Millisecond, second and scan interval tick generator
module wdf_tick_gen #(
  parameter int MS_CYCLES = wdf_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Scan interval code
  input wire logic [wdf_pkg::SCAN_CODE_W-1:0] scan_code,
  // Ticks
  output logic sec_tick,
  output logic scan_tick
);
  import wdf_pkg::*;
  logic [31:0] cyc_q;
  logic [9:0] ms_q;
  logic [16:0] scan_ms_q;
  logic ms_tick;
  logic scan_end;
  logic [3:0] code_c;
  logic [16:0] scan_len;
  logic sec_q;
  logic scan_q;

  // ==========================================
  // Dividers
  assign ms_tick = cyc_q == 32'(MS_CYCLES - 1);
  // Codes past the top step stay at the slowest interval
  assign code_c = (scan_code > SCAN_CODE_MAX) ? SCAN_CODE_MAX : scan_code;
  assign scan_len = 17'(BASE_SCAN_MS) << code_c;
  assign scan_end = ms_tick && (scan_ms_q >= 17'(scan_len - 17'h00001));
  assign sec_tick = sec_q;
  assign scan_tick = scan_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_q <= 32'h00000000;
      ms_q <= 10'h000;
      scan_ms_q <= 17'h00000;
      sec_q <= 1'b0;
      scan_q <= 1'b0;
    end else begin
      cyc_q <= ms_tick ? 32'h00000000 : 32'(cyc_q + 32'h00000001);
      if (ms_tick) begin
        ms_q <= (ms_q == 10'(MS_PER_SEC - 1)) ? 10'h000 : 10'(ms_q + 10'h001);
        scan_ms_q <= scan_end ? 17'h00000 : 17'(scan_ms_q + 17'h00001);
      end
      sec_q <= ms_tick && (ms_q == 10'(MS_PER_SEC - 1));
      scan_q <= scan_end;
    end
  end
endmodule : wdf_tick_gen

// >>> logic/wdf_totalizer.sv
// Consecutive faulty scan counter, one per cell
module wdf_totalizer #(
  parameter int CELLS = 14
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Scan results
  wdf_scan_if.tot scan,
  input wire logic [CELLS-1:0] fault_raw,
  // Alarms, one cycle each
  output logic [CELLS-1:0] alarm
);
  import wdf_pkg::*;
  logic [8:0] need;
  logic [CELLS-1:0] hit;
  logic [CELLS-1:0] alarm_q;

  assign need = 9'h001 << scan.thr_code;
  assign alarm = alarm_q;

  // ==========================================
  // Per cell counters
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic [7:0] cnt_q;
    assign hit[i] = scan.scan_done && fault_raw[i] && (9'(cnt_q) + 9'h001 >= need);
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        cnt_q <= 8'h00;
      end else if (scan.scan_done) begin
        // A clean scan breaks the run
        cnt_q <= !fault_raw[i] ? 8'h00 : (cnt_q == 8'hFF) ? cnt_q : 8'(cnt_q + 8'h01);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= hit;
    end
  end
endmodule : wdf_totalizer

// >>> logic/wdf_watchdog_alarm.sv
// Communications watchdog, fault summary, alarm pin and fault response
// ==========================================
module wdf_watchdog_alarm #(
  parameter int CELLS = 14,
  parameter int MS_CYCLES = wdf_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire logic [wdf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wdf_pkg::DATA_W-1:0] reg_rdata,
  // Link events
  input wire logic valid_comm,
  input wire logic bcast_cmd,
  input wire logic wake_cmd,
  input wire logic sleep_cmd,
  input wire logic wake_from_upper,
  input wire logic wake_ack,
  input wire logic port_busy,
  input wire logic page1_multi_rd,
  input wire logic resp_done,
  input wire logic is_bottom,
  // Measurement engine
  input wire logic scan_done,
  input wire logic [CELLS-1:0] ov_raw,
  input wire logic [CELLS-1:0] uv_raw,
  input wire logic [CELLS-1:0] open_wire_raw,
  input wire logic [CELLS-1:0] otemp_raw,
  input wire logic open_supply_raw,
  input wire logic balance_start,
  input wire logic balance_end,
  // Control outputs
  output logic scan_start,
  output logic balance_en,
  output logic sleep_mode,
  output logic fault_n,
  output logic status_in_read,
  // Fault response
  output logic fault_resp_req,
  output logic [wdf_pkg::DATA_W-1:0] fault_resp_data,
  output logic wake_tx,
  output logic response_ready_n
);
  import wdf_pkg::*;

  // ==========================================
  // State
  logic [7:0] timeout_q;
  logic [DATA_W-1:0] setup1_q;
  logic [7:0] scan_cfg_q;
  logic [NDATA-1:0][CELLS-1:0] data_q;
  logic open_sup_q;
  logic watchdog_fail_flag_q;
  logic [WD_SEC_W-1:0] wd_cnt_q;
  logic sleep_q;
  logic balance_q;
  logic scan_start_q;
  logic fault_n_q;
  logic armed_q;
  logic upper_q;
  logic rdy_n_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] resp_data_q;
  wdf_resp_st_t st_q;
  wdf_resp_st_t st_d;

  // ==========================================
  // Decode
  logic wr_wdg;
  logic wr_setup1;
  logic wr_scan;
  logic wr_status;
  logic data_sel;
  logic [NDATA-1:0] wr_data;
  logic zero_ok;
  logic wdg_load;
  assign wr_wdg = reg_wr && (reg_addr == ADR_WDG);
  assign wr_setup1 = reg_wr && (reg_addr == ADR_SETUP1);
  assign wr_scan = reg_wr && (reg_addr == ADR_SCAN);
  assign wr_status = reg_wr && (reg_addr == ADR_STATUS);
  assign data_sel = reg_addr[ADDR_W-1:2] == ADR_DATA0[ADDR_W-1:2];
  for (genvar i = 0; i < NDATA; i++) begin : g_wr
    assign wr_data[i] = reg_wr && data_sel && (reg_addr[1:0] == 2'(i));
  end
  // Password guards against a stray write turning the watchdog off
  assign zero_ok = setup1_q[UNLOCK_MSB:UNLOCK_LSB] == UNLOCK_KEY;
  assign wdg_load = wr_wdg && ((reg_wdata[7:0] != WDG_OFF) || zero_ok);

  // ==========================================
  // Ticks and totalizers
  logic sec_tick;
  logic scan_tick;
  logic [CELLS-1:0] ov_alarm;
  logic [CELLS-1:0] uv_alarm;
  wdf_scan_if scan_bus ();
  assign scan_bus.scan_done = scan_done;
  assign scan_bus.thr_code = scan_cfg_q[THR_LSB+2:THR_LSB];

  wdf_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .scan_code(scan_cfg_q[SCAN_CODE_LSB+SCAN_CODE_W-1:SCAN_CODE_LSB]),
    .sec_tick(sec_tick),
    .scan_tick(scan_tick)
  );
  wdf_totalizer #(.CELLS(CELLS)) u_tot_ov (
    .ref_clk(ref_clk),
    .srst(srst),
    .scan(scan_bus),
    .fault_raw(ov_raw),
    .alarm(ov_alarm)
  );
  wdf_totalizer #(.CELLS(CELLS)) u_tot_uv (
    .ref_clk(ref_clk),
    .srst(srst),
    .scan(scan_bus),
    .fault_raw(uv_raw),
    .alarm(uv_alarm)
  );

  // ==========================================
  // Watchdog
  logic restart;
  logic wd_on;
  logic expire;
  logic [WD_SEC_W-1:0] wd_limit;
  assign restart = valid_comm || bcast_cmd || wdg_load;
  assign wd_limit = wdf_timeout_sec(timeout_q);
  assign wd_on = timeout_q != WDG_OFF;
  assign expire = wd_on && !restart && sec_tick &&
                  (WD_SEC_W'(wd_cnt_q + 1'b1) >= wd_limit);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timeout_q <= WDG_RST;
    end else if (wdg_load) begin
      timeout_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || restart || expire) begin
      wd_cnt_q <= '0;
    end else if (sec_tick && wd_on) begin
      wd_cnt_q <= WD_SEC_W'(wd_cnt_q + 1'b1);
    end
  end

  // ==========================================
  // Configuration
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      setup1_q <= '0;
    end else if (wr_setup1) begin
      setup1_q <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scan_cfg_q <= SCAN_RST;
    end else begin
      if (wr_scan) begin
        scan_cfg_q <= reg_wdata[7:0];
      end
      // Safety stop beats a racing software write
      if (expire) begin
        scan_cfg_q[SCAN_CONT_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================
  // Fault data and summary
  logic [NDATA-1:0][CELLS-1:0] set_v;
  logic [NDATA-1:0] summary;
  logic any_fault;
  logic resp_fault;
  logic scan_cont;
  assign scan_cont = scan_cfg_q[SCAN_CONT_BIT];
  assign set_v[DIDX_OV] = ov_alarm;
  assign set_v[DIDX_UV] = uv_alarm;
  assign set_v[DIDX_OW] = scan_done ? open_wire_raw : '0;
  assign set_v[DIDX_OT] = scan_done ? otemp_raw : '0;
  for (genvar i = 0; i < NDATA; i++) begin : g_data
    assign summary[i] = |data_q[i];
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        data_q[i] <= '0;
      end else begin
        // New fault bits win over a clearing write
        data_q[i] <= (wr_data[i] ? reg_wdata[CELLS-1:0] : data_q[i]) | set_v[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      open_sup_q <= 1'b0;
      watchdog_fail_flag_q <= 1'b0;
    end else begin
      open_sup_q <= (wr_status ? reg_wdata[ST_OPEN_BIT] : open_sup_q) ||
                    (scan_done && open_supply_raw);
      watchdog_fail_flag_q <= (wr_status ? reg_wdata[ST_WATCHDOG_FAIL_FLAG_BIT] : watchdog_fail_flag_q) || expire;
    end
  end

  logic [DATA_W-1:0] status_word;
  assign status_word = DATA_W'({watchdog_fail_flag_q, open_sup_q, summary});
  assign resp_fault = (|summary) || open_sup_q;
  assign any_fault = resp_fault || watchdog_fail_flag_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_n_q <= 1'b1;
    end else begin
      fault_n_q <= !(any_fault || (|set_v) || (scan_done && open_supply_raw));
    end
  end

  // ==========================================
  // Sleep, scan and balance
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sleep_q <= 1'b0;
      balance_q <= 1'b0;
      scan_start_q <= 1'b0;
    end else begin
      if (expire || sleep_cmd) begin
        sleep_q <= 1'b1;
      end else if (wake_cmd || wake_from_upper || wake_ack) begin
        sleep_q <= 1'b0;
      end
      if (expire || balance_end) begin
        balance_q <= 1'b0;
      end else if (balance_start) begin
        balance_q <= 1'b1;
      end
      scan_start_q <= scan_tick && scan_cont && !expire;
    end
  end

  // ==========================================
  // Fault response sequencer
  logic trig;
  assign trig = scan_cont && resp_fault && armed_q;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RS_IDLE: begin
        if (trig) begin
          st_d = sleep_q ? RS_WAKE : RS_HOLD;
        end
      end
      RS_WAKE: begin
        st_d = RS_WAIT_ACK;
      end
      RS_WAIT_ACK: begin
        if (wake_ack) begin
          st_d = RS_HOLD;
        end
      end
      RS_HOLD: begin
        if (!port_busy) begin
          st_d = RS_SEND;
        end
      end
      RS_SEND: begin
        st_d = RS_WAIT_DONE;
      end
      RS_WAIT_DONE: begin
        if (resp_done) begin
          st_d = RS_IDLE;
        end
      end
      default: begin
        st_d = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= RS_IDLE;
      armed_q <= 1'b1;
      resp_data_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_q == RS_IDLE && trig) begin
        armed_q <= 1'b0;
      end else if (!resp_fault) begin
        armed_q <= 1'b1;
      end
      if (st_d == RS_SEND) begin
        resp_data_q <= status_word;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      upper_q <= 1'b0;
      rdy_n_q <= 1'b1;
    end else begin
      // A wake in the same cycle as a finished response must not be lost
      if (wake_from_upper && is_bottom) begin
        upper_q <= 1'b1;
      end else if (resp_done) begin
        upper_q <= 1'b0;
      end
      rdy_n_q <= !(is_bottom && (upper_q || st_d == RS_SEND || st_d == RS_WAIT_DONE));
    end
  end

  // ==========================================
  // Register read
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] state_word;
  assign state_word = DATA_W'({st_q, balance_q, sleep_q, !fault_n_q});
  assign rd_mux = (reg_addr == ADR_WDG) ? DATA_W'(timeout_q) :
                  (reg_addr == ADR_SETUP1) ? setup1_q :
                  (reg_addr == ADR_SCAN) ? DATA_W'(scan_cfg_q) :
                  (reg_addr == ADR_STATUS) ? status_word :
                  data_sel ? DATA_W'(data_q[reg_addr[1:0]]) :
                  (reg_addr == ADR_STATE) ? state_word : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata = rdata_q;
  assign scan_start = scan_start_q;
  assign balance_en = balance_q;
  assign sleep_mode = sleep_q;
  assign fault_n = fault_n_q;
  // Outside scan continuous the host pulls the status itself
  assign status_in_read = page1_multi_rd && !scan_cont;
  assign fault_resp_req = st_q == RS_SEND;
  assign fault_resp_data = resp_data_q;
  assign wake_tx = st_q == RS_WAKE;
  assign response_ready_n = rdy_n_q;

  // ==========================================
  // Checks
  sequence s_woken;
    wake_tx ##1 (st_q == RS_WAIT_ACK);
  endsequence
  sequence s_clear_path;
    (st_q == RS_HOLD) && !port_busy;
  endsequence

  AST_ZERO_LOCK: assert property (@(posedge ref_clk) disable iff (srst)
    wr_wdg && reg_wdata[7:0] == WDG_OFF && !zero_ok |=> timeout_q == $past(timeout_q))
    else $error("Locked zero write changed timeout");
  AST_OFF_SILENT: assert property (@(posedge ref_clk) disable iff (srst)
    timeout_q == WDG_OFF |-> !expire)
    else $error("Disabled watchdog expired");
  AST_EXPIRE_ACT: assert property (@(posedge ref_clk) disable iff (srst)
    expire |=> watchdog_fail_flag_q && sleep_q && !scan_cont && !balance_q ##1 !fault_n_q)
    else $error("Expiry actions missing");
  AST_NO_WDG_RESP: assert property (@(posedge ref_clk) disable iff (srst)
    expire && st_q == RS_IDLE && !trig |=> st_q == RS_IDLE)
    else $error("Expiry started a fault response");
  AST_ALARM_SET: assert property (@(posedge ref_clk) disable iff (srst)
    (|summary) |=> !fault_n_q)
    else $error("Alarm not low on fault");
  AST_FIRST_ONLY: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == RS_SEND |-> !armed_q)
    else $error("Response sent while armed");
  AST_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
    fault_resp_req |-> $past(st_q) == RS_HOLD && !$past(port_busy))
    else $error("Response sent during port activity");
  AST_GAP: assert property (@(posedge ref_clk) disable iff (srst)
    s_clear_path |-> ##[1:2] fault_resp_req)
    else $error("Delayed response late");
  AST_WAKE_FIRST: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == RS_IDLE && trig && sleep_q |=> s_woken)
    else $error("Sleeping device did not send wake");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (srst)
    valid_comm || bcast_cmd |=> wd_cnt_q == '0)
    else $error("Watchdog not restarted");
endmodule : wdf_watchdog_alarm

// >>> shared/wdf_pkg.sv
// Constants, types and helpers for the watchdog and fault alarm block
package wdf_pkg;
  // ==========================================
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADR_WDG = 4'h0;
  localparam logic [3:0] ADR_SETUP1 = 4'h1;
  localparam logic [3:0] ADR_SCAN = 4'h2;
  localparam logic [3:0] ADR_STATUS = 4'h3;
  localparam logic [3:0] ADR_DATA0 = 4'h4;
  localparam logic [3:0] ADR_STATE = 4'h8;
  localparam int NDATA = 4;
  localparam int DIDX_OV = 0;
  localparam int DIDX_UV = 1;
  localparam int DIDX_OW = 2;
  localparam int DIDX_OT = 3;
  // ==========================================
  // Field positions and reset values
  localparam int UNLOCK_LSB = 6;
  localparam int UNLOCK_MSB = 11;
  localparam logic [5:0] UNLOCK_KEY = 6'h3A;
  localparam logic [7:0] WDG_RST = 8'h3F;
  localparam logic [7:0] WDG_OFF = 8'h00;
  localparam logic [7:0] WDG_MID2 = 8'h40;
  localparam logic [7:0] WDG_MID4 = 8'h41;
  localparam int SCAN_CODE_W = 4;
  localparam int SCAN_CODE_LSB = 0;
  localparam int THR_LSB = 4;
  localparam int SCAN_CONT_BIT = 7;
  localparam logic [7:0] SCAN_RST = 8'h00;
  localparam logic [3:0] SCAN_CODE_MAX = 4'hC;
  localparam int ST_OPEN_BIT = 4;
  localparam int ST_WATCHDOG_FAIL_FLAG_BIT = 5;
  // ==========================================
  // Timing
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int MS_PER_SEC = 1000;
  localparam int BASE_SCAN_MS = 16;
  localparam int RESP_GAP_NS = 68000;
  localparam int RESP_GAP_CYC = RESP_GAP_NS / CLK_NS;
  localparam int WD_SEC_W = 17;
  localparam logic [16:0] SEC_2MIN = 17'h00078;
  localparam logic [16:0] SEC_4MIN = 17'h000F0;
  localparam logic [16:0] SEC_8MIN = 17'h001E0;
  // ==========================================
  // Fault response sequencer states
  typedef enum logic [2:0] {
    RS_IDLE = 3'h0,
    RS_WAKE = 3'h1,
    RS_WAIT_ACK = 3'h2,
    RS_HOLD = 3'h3,
    RS_SEND = 3'h4,
    RS_WAIT_DONE = 3'h5
  } wdf_resp_st_t;

  // Seconds selected by a timeout code; zero means off
  function automatic logic [16:0] wdf_timeout_sec(input logic [7:0] code);
    logic [16:0] steps;
    steps = 17'(code - WDG_MID4);
    if (code <= WDG_RST) begin
      wdf_timeout_sec = {9'h000, code};
    end else if (code == WDG_MID2) begin
      wdf_timeout_sec = SEC_2MIN;
    end else if (code == WDG_MID4) begin
      wdf_timeout_sec = SEC_4MIN;
    end else begin
      wdf_timeout_sec = 17'(steps * SEC_8MIN);
    end
  endfunction : wdf_timeout_sec
endpackage : wdf_pkg

// >>> shared/wdf_scan_if.sv
// Scan completion and threshold carried to the fault totalizer
interface wdf_scan_if;
  logic scan_done;
  logic [2:0] thr_code;
  modport ctl (output scan_done, output thr_code);
  modport tot (input scan_done, input thr_code);
endinterface : wdf_scan_if

// >>> verification/wdf_link_model.sv
// Behavioural link partner: answers wake requests and fault responses
module wdf_link_model #(
  parameter int DLY = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // From the block
  input wire logic fault_resp_req,
  input wire logic [wdf_pkg::DATA_W-1:0] fault_resp_data,
  input wire logic wake_tx,
  // Answers and observations
  output logic resp_done,
  output logic wake_ack,
  output logic [7:0] resp_cnt_q,
  output logic [wdf_pkg::DATA_W-1:0] resp_data_q
);
  timeunit 1ns;
  timeprecision 100ps;
  int rc_q;
  int wc_q;
  // ==========================================
  // Slow answers, so the sequencer must wait
  always @(posedge ref_clk) begin
    resp_done <= 1'b0;
    wake_ack <= 1'b0;
    if (srst) begin
      rc_q <= 0;
      wc_q <= 0;
      resp_cnt_q <= 8'h00;
      resp_data_q <= 16'h0000;
    end else begin
      if (rc_q != 0) rc_q <= rc_q - 1;
      if (wc_q != 0) wc_q <= wc_q - 1;
      if (rc_q == 1) resp_done <= 1'b1;
      if (wc_q == 1) wake_ack <= 1'b1;
      if (fault_resp_req) begin
        rc_q <= DLY;
        resp_cnt_q <= resp_cnt_q + 8'h01;
        resp_data_q <= fault_resp_data;
      end
      if (wake_tx) wc_q <= DLY;
    end
  end
endmodule : wdf_link_model

// >>> verification/wdf_watchdog_alarm_tb.sv
// Self-checking bench for the watchdog and fault alarm block
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h seen %h", nm, e, g); end end
module wdf_watchdog_alarm_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wdf_pkg::*;
  // Short second keeps the run small: 10000 cycles
  localparam int MSC = 10;
  localparam int SEC = MSC * MS_PER_SEC;
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, resp_data;
  logic valid_comm = 1'b0, bcast_cmd = 1'b0, wake_cmd = 1'b0, port_busy = 1'b0, page1 = 1'b0;
  logic scan_done = 1'b0, os_raw = 1'b0, bal_start = 1'b0;
  logic sleep_cmd = 1'b0, wake_upper = 1'b0, is_bot = 1'b0;
  logic [13:0] ov_raw = '0, uv_raw = '0, ow_raw = '0, ot_raw = '0;
  logic wake_ack, resp_done, scan_start, balance_en, sleep_mode, fault_n, status_in_read;
  logic fault_resp_req, wake_tx, response_ready_n;
  logic [15:0] fault_resp_data;
  logic [7:0] resp_cnt;
  int err_count = 0;
  int checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  wdf_watchdog_alarm #(.CELLS(14), .MS_CYCLES(MSC)) dut (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .valid_comm(valid_comm), .bcast_cmd(bcast_cmd), .wake_cmd(wake_cmd), .sleep_cmd(sleep_cmd),
    .wake_from_upper(wake_upper), .wake_ack(wake_ack), .port_busy(port_busy), .page1_multi_rd(page1),
    .resp_done(resp_done), .is_bottom(is_bot), .scan_done(scan_done), .ov_raw(ov_raw), .uv_raw(uv_raw),
    .open_wire_raw(ow_raw), .otemp_raw(ot_raw), .open_supply_raw(os_raw), .balance_start(bal_start),
    .balance_end(1'b0), .scan_start(scan_start), .balance_en(balance_en), .sleep_mode(sleep_mode),
    .fault_n(fault_n), .status_in_read(status_in_read), .fault_resp_req(fault_resp_req),
    .fault_resp_data(fault_resp_data), .wake_tx(wake_tx), .response_ready_n(response_ready_n));
  wdf_link_model #(.DLY(20)) phy (.ref_clk(ref_clk), .srst(srst), .fault_resp_req(fault_resp_req),
    .fault_resp_data(fault_resp_data), .wake_tx(wake_tx), .resp_done(resp_done), .wake_ack(wake_ack),
    .resp_cnt_q(resp_cnt), .resp_data_q(resp_data));
  // ==========================================
  // Bus and stimulus helpers
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task chk_reg(input string nm, input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask : chk_reg
  task scan(input logic [13:0] ov, input logic [13:0] uv, input logic [13:0] ow, input logic [13:0] ot,
            input logic os);
    @(posedge ref_clk);
    scan_done <= 1'b1;
    {ov_raw, uv_raw, ow_raw, ot_raw, os_raw} <= {ov, uv, ow, ot, os};
    @(posedge ref_clk);
    scan_done <= 1'b0;
    {ov_raw, uv_raw, ow_raw, ot_raw, os_raw} <= '0;
    cyc(4);
  endtask : scan
  // ==========================================
  // Scenarios
  task t_lock;
    chk_reg("timeout code", ADR_WDG, 16'h003F);
    `CHK("fault_n", 1'b1, fault_n)
    // A refused zero would leave one second and expire in the wait below
    wr(ADR_WDG, 16'h0001);
    wr(ADR_WDG, 16'h0000);
    chk_reg("locked zero", ADR_WDG, 16'h0001);
    wr(ADR_SETUP1, 16'h0E80);
    wr(ADR_WDG, 16'h0000);
    chk_reg("unlocked zero", ADR_WDG, 16'h0000);
    cyc(2 * SEC + 100);
    `CHK("sleep off", 1'b0, sleep_mode)
    wr(ADR_SETUP1, 16'h0000);
    wr(ADR_WDG, 16'h003F);
  endtask : t_lock
  task t_fault;
    wr(ADR_SCAN, 16'h0080);
    page1 <= 1'b1;
    scan('0, '0, 14'h0008, '0, 1'b0);
    `CHK("fault_n", 1'b0, fault_n)
    `CHK("status in read", 1'b0, status_in_read)
    cyc(30);
    `CHK("responses", 8'h01, resp_cnt)
    `CHK("resp data", 16'h0004, resp_data)
    scan('0, '0, '0, 14'h0001, 1'b0);
    cyc(30);
    `CHK("responses", 8'h01, resp_cnt)
    chk_reg("status", ADR_STATUS, 16'h000C);
    wr(4'h6, 16'h0000);
    cyc(2);
    `CHK("fault_n", 1'b0, fault_n)
    wr(4'h7, 16'h0000);
    cyc(2);
    `CHK("fault_n", 1'b1, fault_n)
    wr(ADR_SCAN, 16'h0000);
    cyc(1);
    `CHK("status in read", 1'b1, status_in_read)
    page1 <= 1'b0;
  endtask : t_fault
  task t_total;
    // Threshold code 1: two unbroken faulty scans
    wr(ADR_SCAN, 16'h0090);
    port_busy <= 1'b1;
    scan(14'h0001, 14'h0002, '0, '0, 1'b0);
    chk_reg("one scan", ADR_STATUS, 16'h0000);
    scan(14'h0001, '0, '0, '0, 1'b0);
    chk_reg("two scans", ADR_STATUS, 16'h0001);
    cyc(20);
    `CHK("held", 8'h01, resp_cnt)
    port_busy <= 1'b0;
    cyc(30);
    `CHK("released", 8'h02, resp_cnt)
    scan('0, '0, '0, '0, 1'b1);
    chk_reg("open supply", ADR_STATUS, 16'h0011);
    wr(ADR_DATA0, 16'h0000);
    wr(ADR_STATUS, 16'h0000);
    cyc(2);
    `CHK("fault_n", 1'b1, fault_n)
  endtask : t_total
  task t_sleep_resp;
    is_bot <= 1'b1;
    wake_upper <= 1'b1;
    cyc(1);
    wake_upper <= 1'b0;
    cyc(2);
    `CHK("ready low", 1'b0, response_ready_n)
    sleep_cmd <= 1'b1;
    cyc(1);
    sleep_cmd <= 1'b0;
    scan('0, '0, 14'h0001, '0, 1'b0);
    `CHK("asleep", 1'b1, sleep_mode)
    `CHK("not yet", 8'h02, resp_cnt)
    cyc(30);
    `CHK("after ack", 8'h03, resp_cnt)
    `CHK("woken", 1'b0, sleep_mode)
    cyc(20);
    `CHK("ready high", 1'b1, response_ready_n)
    wr(4'h6, 16'h0000);
    is_bot <= 1'b0;
  endtask : t_sleep_resp
  task t_watchdog;
    int i;
    int n;
    for (i = 0; i < 200 && scan_start !== 1'b1; i++) cyc(1);
    `CHK("scan start", 1'b1, scan_start)
    @(posedge ref_clk);
    bal_start <= 1'b1;
    @(posedge ref_clk);
    bal_start <= 1'b0;
    wr(ADR_WDG, 16'h0002);
    cyc(9000);
    bcast_cmd <= 1'b1;
    cyc(1);
    bcast_cmd <= 1'b0;
    cyc(9000);
    valid_comm <= 1'b1;
    cyc(1);
    valid_comm <= 1'b0;
    cyc(9000);
    `CHK("restarted", 1'b0, sleep_mode)
    `CHK("balance on", 1'b1, balance_en)
    for (i = 0; i < 2 * SEC + 100 && sleep_mode !== 1'b1; i++) cyc(1);
    cyc(3);
    `CHK("sleep", 1'b1, sleep_mode)
    `CHK("fault_n", 1'b0, fault_n)
    `CHK("balance off", 1'b0, balance_en)
    `CHK("no response", 8'h03, resp_cnt)
    chk_reg("scan cont off", ADR_SCAN, 16'h0010);
    n = 0;
    repeat (400) begin
      cyc(1);
      n += int'(scan_start);
    end
    `CHK("scans after expiry", 0, n)
    wake_cmd <= 1'b1;
    cyc(1);
    wake_cmd <= 1'b0;
    cyc(2);
    `CHK("awake", 1'b0, sleep_mode)
    chk_reg("fail flag", ADR_STATUS, 16'h0020);
  endtask : t_watchdog
  task report_and_stop;
    $display("err_count=%0d checked=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(3);
    srst <= 1'b0;
    t_lock();
    t_fault();
    t_total();
    t_sleep_resp();
    t_watchdog();
    report_and_stop();
  end
  // Cut a hang short well past the expected run
  initial begin
    cyc(95000);
    err_count++;
    report_and_stop();
  end
endmodule : wdf_watchdog_alarm_tb
